/* verilog/bpio_pkg.sv */
// constants and types for the bidirectional port block
package bpio_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_PA_DATA = 8'h00;
  localparam logic [7:0] ADDR_PA_DIR = 8'h01;
  localparam logic [7:0] ADDR_PA_PU = 8'h02;
  localparam logic [7:0] ADDR_PA_WU = 8'h03;
  localparam logic [7:0] ADDR_PB_DATA = 8'h04;
  localparam logic [7:0] ADDR_PB_DIR = 8'h05;
  localparam logic [7:0] ADDR_PB_PU = 8'h06;
  localparam logic [7:0] ADDR_PC_DATA = 8'h07;
  localparam logic [7:0] ADDR_PC_DIR = 8'h08;
  localparam logic [7:0] ADDR_PC_PU = 8'h09;
  // implemented bit masks per port
  localparam logic [7:0] MASK_A = 8'hff;
  localparam logic [7:0] MASK_B = 8'h0f;
  localparam logic [7:0] MASK_C = 8'h3f;
  // reserved bit of port B, held at a fixed value
  localparam logic [7:0] RSVD_B = 8'h10;
  localparam logic [7:0] RSVD_B_VAL = 8'h00;
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PU = 8'h00;
  localparam logic [7:0] RST_WU = 8'h00;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  // register bus request
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bpio_req_t;
  // per-port pad view
  typedef struct packed {
    logic [7:0] outVal;
    logic [7:0] outEn;
    logic [7:0] pullEn;
  } bpio_pad_t;
endpackage

/* verilog/bpio_port.sv */
// three bidirectional gpio ports with pull-ups and port A wake-up
`timescale 1ns/1ps
module bpio_port (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire bpio_pkg::bpio_req_t req,
  output logic [7:0] rdata,
  input wire logic [7:0] padAIn,
  input wire logic [7:0] padBIn,
  input wire logic [7:0] padCIn,
  output bpio_pkg::bpio_pad_t padA,
  output bpio_pkg::bpio_pad_t padB,
  output bpio_pkg::bpio_pad_t padC,
  input wire logic [7:0] gpioSelA,
  input wire logic [7:0] gpioSelB,
  input wire logic [7:0] gpioSelC,
  input wire logic [7:0] openDrainA,
  input wire logic [7:0] openDrainB,
  input wire logic [7:0] openDrainC,
  input wire logic powerDown,
  output logic wakeReq
);
  import bpio_pkg::*;

  logic [7:0] dataA_q, dirA_q, puA_q, wuA_q;
  logic [7:0] dataB_q, dirB_q, puB_q;
  logic [7:0] dataC_q, dirC_q, puC_q;
  logic [7:0] syncA1_q, syncA2_q, syncB1_q, syncB2_q, syncC1_q, syncC2_q;
  logic [7:0] prevA_q;
  logic [7:0] rdata_d;

  // merge a write into a register, clearing unimplemented bits and keeping reserved bits
  function automatic logic [7:0] wmask(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask, input logic [7:0] rsv);
    wmask = (wd & mask & ~rsv) | (old & rsv);
  endfunction

  // readback: latch for outputs, synchronised pad for inputs
  function automatic logic [7:0] rdport(input logic [7:0] dat, input logic [7:0] dir,
                                        input logic [7:0] pin, input logic [7:0] mask);
    rdport = ((dir & pin) | (~dir & dat)) & mask;
  endfunction

  // two-flop synchronisers on pad inputs; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      syncA1_q <= ALL_ZERO;
      syncA2_q <= ALL_ZERO;
      syncB1_q <= ALL_ZERO;
      syncB2_q <= ALL_ZERO;
      syncC1_q <= ALL_ZERO;
      syncC2_q <= ALL_ZERO;
    end else begin
      syncA1_q <= padAIn;
      syncA2_q <= syncA1_q;
      syncB1_q <= padBIn;
      syncB2_q <= syncB1_q;
      syncC1_q <= padCIn;
      syncC2_q <= syncC1_q;
    end
  end

  // port A registers; latch changes only on its own write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dataA_q <= RST_DATA & MASK_A;
      dirA_q <= RST_DIR & MASK_A;
      puA_q <= RST_PU;
      wuA_q <= RST_WU;
    end else if (req.wrEn) begin
      if (req.addr == ADDR_PA_DATA) begin
        dataA_q <= wmask(dataA_q, req.wdata, MASK_A, ALL_ZERO);
      end
      if (req.addr == ADDR_PA_DIR) begin
        dirA_q <= wmask(dirA_q, req.wdata, MASK_A, ALL_ZERO);
      end
      if (req.addr == ADDR_PA_PU) begin
        puA_q <= wmask(puA_q, req.wdata, MASK_A, ALL_ZERO);
      end
      if (req.addr == ADDR_PA_WU) begin
        wuA_q <= wmask(wuA_q, req.wdata, MASK_A, ALL_ZERO);
      end
    end
  end

  // port B registers; bit 4 reserved and held
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dataB_q <= (RST_DATA & MASK_B) | RSVD_B_VAL;
      dirB_q <= (RST_DIR & MASK_B) | RSVD_B_VAL;
      puB_q <= RST_PU | RSVD_B_VAL;
    end else if (req.wrEn) begin
      if (req.addr == ADDR_PB_DATA) begin
        dataB_q <= wmask(dataB_q, req.wdata, MASK_B, RSVD_B);
      end
      if (req.addr == ADDR_PB_DIR) begin
        dirB_q <= wmask(dirB_q, req.wdata, MASK_B, RSVD_B);
      end
      if (req.addr == ADDR_PB_PU) begin
        puB_q <= wmask(puB_q, req.wdata, MASK_B, RSVD_B);
      end
    end
  end

  // port C registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dataC_q <= RST_DATA & MASK_C;
      dirC_q <= RST_DIR & MASK_C;
      puC_q <= RST_PU;
    end else if (req.wrEn) begin
      if (req.addr == ADDR_PC_DATA) begin
        dataC_q <= wmask(dataC_q, req.wdata, MASK_C, ALL_ZERO);
      end
      if (req.addr == ADDR_PC_DIR) begin
        dirC_q <= wmask(dirC_q, req.wdata, MASK_C, ALL_ZERO);
      end
      if (req.addr == ADDR_PC_PU) begin
        puC_q <= wmask(puC_q, req.wdata, MASK_C, ALL_ZERO);
      end
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    rdata_d = ALL_ZERO;
    case (req.addr)
      ADDR_PA_DATA: rdata_d = rdport(dataA_q, dirA_q, syncA2_q, MASK_A);
      ADDR_PA_DIR: rdata_d = dirA_q;
      ADDR_PA_PU: rdata_d = puA_q;
      ADDR_PA_WU: rdata_d = wuA_q;
      ADDR_PB_DATA: rdata_d = rdport(dataB_q, dirB_q, syncB2_q, MASK_B);
      ADDR_PB_DIR: rdata_d = dirB_q & MASK_B;
      ADDR_PB_PU: rdata_d = puB_q & MASK_B;
      ADDR_PC_DATA: rdata_d = rdport(dataC_q, dirC_q, syncC2_q, MASK_C);
      ADDR_PC_DIR: rdata_d = dirC_q;
      ADDR_PC_PU: rdata_d = puC_q;
      default: rdata_d = ALL_ZERO;
    endcase
  end

  // registered read data, valid the edge after rdEn; level sampled at that edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata <= ALL_ZERO;
    end else if (req.rdEn) begin
      rdata <= rdata_d;
    end
  end

  // pad drive: the latch drives while in output mode, pull-up only when not driving hard
  assign padA.outVal = dataA_q;
  assign padA.outEn = ~dirA_q & MASK_A;
  assign padA.pullEn = puA_q & (dirA_q | openDrainA) & MASK_A;
  assign padB.outVal = dataB_q & MASK_B;
  assign padB.outEn = ~dirB_q & MASK_B;
  assign padB.pullEn = puB_q & (dirB_q | openDrainB) & MASK_B;
  assign padC.outVal = dataC_q & MASK_C;
  assign padC.outEn = ~dirC_q & MASK_C;
  assign padC.pullEn = puC_q & (dirC_q | openDrainC) & MASK_C;

  // previous port A level for falling-edge detection; read only from stage two
  // resets low, so a pin that idles high after reset never shows a false fall
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prevA_q <= ALL_ZERO;
    end else begin
      prevA_q <= syncA2_q;
    end
  end

  // wake pulse: enabled gpio pin falling while powered down
  logic [7:0] fallA;
  assign fallA = prevA_q & ~syncA2_q & wuA_q & gpioSelA;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wakeReq <= 1'b0;
    end else begin
      wakeReq <= powerDown && (fallA != ALL_ZERO);
    end
  end

  // function selects of B and C unused by any logic, pull gating included; kept for symmetry
  logic unusedSel;
  assign unusedSel = ^{gpioSelB, gpioSelC};

  // pull-up never active on a push-pull output, on any port
  chk_pull_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((padA.pullEn & ~dirA_q & ~openDrainA) == ALL_ZERO))
    else $error("pull-up on push-pull output");
  chk_pull_gate_b: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((padB.pullEn & ~dirB_q & ~openDrainB) == ALL_ZERO))
    else $error("port B pull-up on push-pull output");
  chk_pull_gate_c: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((padC.pullEn & ~dirC_q & ~openDrainC) == ALL_ZERO))
    else $error("port C pull-up on push-pull output");

  // data register reads of ports B and C
  sequence readB;
    req.rdEn && (req.addr == ADDR_PB_DATA);
  endsequence
  sequence readC;
    req.rdEn && (req.addr == ADDR_PC_DATA);
  endsequence

  // an input pin reads the synchronised level
  chk_input_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rdEn && req.addr == ADDR_PA_DATA) |=>
      ((rdata & $past(dirA_q)) == ($past(syncA2_q) & $past(dirA_q))))
    else $error("input read mismatch");
  chk_b_input_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    readB |=> ((rdata & $past(dirB_q)) == ($past(syncB2_q) & $past(dirB_q) & MASK_B)))
    else $error("port B input read mismatch");
  chk_c_input_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    readC |=> ((rdata & $past(dirC_q)) == ($past(syncC2_q) & $past(dirC_q) & MASK_C)))
    else $error("port C input read mismatch");

  // an output pin reads the latch, never the pad
  chk_output_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rdEn && req.addr == ADDR_PA_DATA) |=>
      ((rdata & ~$past(dirA_q)) == ($past(dataA_q) & ~$past(dirA_q))))
    else $error("output read mismatch");
  chk_b_output_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    readB |=> ((rdata & ~$past(dirB_q) & MASK_B) ==
      ($past(dataB_q) & ~$past(dirB_q) & MASK_B)))
    else $error("port B output read mismatch");
  chk_c_output_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    readC |=> ((rdata & ~$past(dirC_q) & MASK_C) ==
      ($past(dataC_q) & ~$past(dirC_q) & MASK_C)))
    else $error("port C output read mismatch");

  // latch stable without a write to its own port
  chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(req.wrEn && req.addr == ADDR_PA_DATA) |=> $stable(dataA_q))
    else $error("latch changed without write");
  chk_latch_hold_b: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(req.wrEn && req.addr == ADDR_PB_DATA) |=> $stable(dataB_q))
    else $error("port B latch changed without write");
  chk_latch_hold_c: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(req.wrEn && req.addr == ADDR_PC_DATA) |=> $stable(dataC_q))
    else $error("port C latch changed without write");

  // reserved and unimplemented bits of port B never change
  chk_b_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((dirB_q & ~MASK_B) == RSVD_B_VAL) && ((puB_q & ~MASK_B) == RSVD_B_VAL))
    else $error("port B reserved bit moved");
  chk_b_data_rsvd: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((dataB_q & ~MASK_B) == RSVD_B_VAL))
    else $error("port B data reserved bit moved");

  // unimplemented bits read zero, and so do unmapped addresses
  chk_c_unimpl: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.rdEn |=> ((rdata & ~MASK_C) == ALL_ZERO) || $past(req.addr) < ADDR_PC_DATA)
    else $error("port C high bits nonzero");
  chk_b_unimpl: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rdEn && (req.addr >= ADDR_PB_DATA) && (req.addr <= ADDR_PB_PU)) |=>
      ((rdata & ~MASK_B) == ALL_ZERO))
    else $error("port B high bits nonzero");
  chk_c_high_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    (((dataC_q | dirC_q | puC_q) & ~MASK_C) == ALL_ZERO))
    else $error("port C high register bits set");
  chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rdEn && (req.addr > ADDR_PC_PU)) |=> (rdata == ALL_ZERO))
    else $error("unmapped read nonzero");

  // writes to pull-up and wake enables land at the next edge
  chk_wu_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PA_WU)) |=> (wuA_q == $past(req.wdata)))
    else $error("wake enable write lost");
  chk_pu_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PA_PU)) |=> (puA_q == $past(req.wdata)))
    else $error("port A pull-up write lost");
  chk_pu_write_b: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PB_PU)) |=> (puB_q == ($past(req.wdata) & MASK_B)))
    else $error("port B pull-up write lost");
  chk_pu_write_c: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PC_PU)) |=> (puC_q == ($past(req.wdata) & MASK_C)))
    else $error("port C pull-up write lost");

  // direction and data writes land masked at the next edge
  chk_dir_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PA_DIR)) |=> (dirA_q == $past(req.wdata)))
    else $error("port A direction write lost");
  chk_dir_write_b: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PB_DIR)) |=> (dirB_q == ($past(req.wdata) & MASK_B)))
    else $error("port B direction write lost");
  chk_dir_write_c: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PC_DIR)) |=> (dirC_q == ($past(req.wdata) & MASK_C)))
    else $error("port C direction write lost");
  chk_data_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PA_DATA)) |=> (dataA_q == $past(req.wdata)))
    else $error("port A data write lost");
  chk_data_write_b: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PB_DATA)) |=> (dataB_q == ($past(req.wdata) & MASK_B)))
    else $error("port B data write lost");
  chk_data_write_c: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && (req.addr == ADDR_PC_DATA)) |=> (dataC_q == ($past(req.wdata) & MASK_C)))
    else $error("port C data write lost");

  // read data holds between reads
  chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !req.rdEn |=> $stable(rdata))
    else $error("read data moved without a read");

  // output pins drive their latch
  chk_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
    (padA.outEn == ~dirA_q) && ((padA.outVal & padA.outEn) == (dataA_q & ~dirA_q)))
    else $error("output drive wrong");
  chk_drive_b: assert property (@(posedge clk_sys) disable iff (!rstn)
    (padB.outEn == (~dirB_q & MASK_B)) &&
      ((padB.outVal & padB.outEn) == (dataB_q & ~dirB_q & MASK_B)))
    else $error("port B output drive wrong");
  chk_drive_c: assert property (@(posedge clk_sys) disable iff (!rstn)
    (padC.outEn == (~dirC_q & MASK_C)) &&
      ((padC.outVal & padC.outEn) == (dataC_q & ~dirC_q & MASK_C)))
    else $error("port C output drive wrong");

  // two edges of held reset leave every control register at its reset value;
  // the first edge is skipped because the registers may still be unset there
  sequence rstHeld;
    !rstn ##1 !rstn;
  endsequence
  chk_reset_state: assert property (@(posedge clk_sys)
    rstHeld |-> (dirA_q == (RST_DIR & MASK_A)) && (padB.outEn == ALL_ZERO) &&
      (padC.outEn == ALL_ZERO) && (puA_q == RST_PU) && (puB_q == RST_PU) &&
      (puC_q == RST_PU) && (wuA_q == RST_WU) && !wakeReq)
    else $error("register not at reset value");

  // wake only when powered down, from a real fall on an enabled gpio pin
  sequence fallSeen;
    powerDown && (fallA != ALL_ZERO);
  endsequence
  chk_wake_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
    wakeReq |-> $past(powerDown) && ($past(fallA) != ALL_ZERO))
    else $error("wake without cause");
  chk_wake_fire: assert property (@(posedge clk_sys) disable iff (!rstn)
    fallSeen |=> wakeReq)
    else $error("missed wake");
  chk_wake_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
    wakeReq |-> (($past(wuA_q) & $past(gpioSelA)) != ALL_ZERO))
    else $error("wake from disabled pin");
  chk_wake_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
    wakeReq |-> (($past(prevA_q) & ~$past(syncA2_q)) != ALL_ZERO))
    else $error("wake without falling edge");
endmodule

/* tb/bpio_pad_model.sv */
// board side of the pads: external drivers, weak pull-ups, floating lines
`timescale 1ns/1ps
module bpio_pad_model (
  input wire logic clk_sys,
  input wire bpio_pkg::bpio_pad_t pad,
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  output logic [7:0] lvl
);
  import bpio_pkg::*;
  logic [7:0] floatQ = 8'h5a;
  // an undriven line wanders, so a missing pull-up cannot pass by luck
  always @(posedge clk_sys) begin
    floatQ <= ~floatQ;
  end
  // device drive wins, then the board, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.outEn[i]) lvl[i] = pad.outVal[i];
      else if (extEn[i]) lvl[i] = extVal[i];
      else if (pad.pullEn[i]) lvl[i] = 1'b1;
      else lvl[i] = floatQ[i];
    end
  end
endmodule

/* tb/tb_bpio_port.sv */
// self-checking bench for the three gpio ports
`timescale 1ns/1ps
module tb_bpio_port;
  import bpio_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  bpio_req_t req = '0;
  logic [7:0] rdata;
  logic [7:0] lvl [3];
  logic [7:0] extV [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] extE [3] = '{8'hff, 8'hff, 8'hff};
  logic [7:0] od [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] mk [3] = '{8'hff, 8'h0f, 8'h3f};
  logic [7:0] base [3] = '{8'h00, 8'h04, 8'h07};
  logic [7:0] gsel = 8'hff;
  logic pd = 1'b0;
  logic wake;
  bpio_pad_t pad [3];
  int failures = 0;
  int samples_checked = 0;
  int seed = 37777;
  always #20 clk_sys = ~clk_sys;
  bpio_port u_dut (.clk_sys(clk_sys), .rstn(rstn), .req(req), .rdata(rdata),
    .padAIn(lvl[0]), .padBIn(lvl[1]), .padCIn(lvl[2]),
    .padA(pad[0]), .padB(pad[1]), .padC(pad[2]),
    .gpioSelA(gsel), .gpioSelB(8'hff), .gpioSelC(8'hff), // no capture input routed
    .openDrainA(od[0]), .openDrainB(od[1]), .openDrainC(od[2]),
    .powerDown(pd), .wakeReq(wake));
  for (genvar g = 0; g < 3; g++) begin : g_pad
    bpio_pad_model u_pad (.clk_sys(clk_sys), .pad(pad[g]), .extVal(extV[g]),
      .extEn(extE[g]), .lvl(lvl[g]));
  end
  // one access per call, with an idle cycle after it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req = '{wrEn: w, rdEn: ~w, addr: a, wdata: d};
    @(negedge clk_sys);
    req = '0;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(e, rdata);
  endtask
  // outputs read the latch, inputs the board level or the pull-up
  function automatic logic [7:0] exp_pin(input int p, input logic [7:0] d, dir, pu);
    logic [7:0] inLvl;
    inLvl = (extV[p] & extE[p]) | (pu & ~extE[p]);
    return ((d & ~dir) | (inLvl & dir)) & mk[p];
  endfunction
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the tests need about 1130 cycles
  initial begin
    #240000;
    failures++;
    end_of_test();
  end
  initial begin
    logic [7:0] d, dir, pu, w, s;
    int p, n;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'b1;
    for (p = 0; p < 3; p++) begin
      chk_rd(base[p] + 8'h01, mk[p]);
      chk_rd(base[p] + 8'h02, 8'h00);
      chk(8'h00, pad[p].outEn);
    end
    chk_rd(8'h03, 8'h00);
    chk_rd(8'h0a, 8'h00);
    $display("test reset done");
    // random direction, latch, pull-up and board levels on every port
    for (int i = 0; i < 60; i++) begin
      p = i % 3;
      d = 8'($random(seed));
      dir = (i < 3) ? 8'h00 : 8'($random(seed));
      pu = 8'($random(seed));
      extV[p] = 8'($random(seed));
      extE[p] = ~pu;
      od[p] = 8'($random(seed));
      acc(1'b1, base[p], d);
      acc(1'b1, base[p] + 8'h01, dir);
      acc(1'b1, base[p] + 8'h02, pu);
      repeat (3) @(negedge clk_sys);
      chk_rd(base[p] + 8'h01, dir & mk[p]);
      chk_rd(base[p] + 8'h02, pu & mk[p]);
      chk_rd(base[p], exp_pin(p, d, dir, pu));
      chk(~dir & mk[p], pad[p].outEn);
      chk(d & ~dir & mk[p], pad[p].outVal & pad[p].outEn);
      chk(pu & (dir | od[p]) & mk[p], pad[p].pullEn);
    end
    $display("test ports done");
    // falling edges on port A with random enables, powered down in three of every four rounds
    acc(1'b1, 8'h01, 8'hff);
    extE[0] = 8'hff;
    for (int i = 0; i < 16; i++) begin
      w = 8'($random(seed));
      s = 8'($random(seed));
      extV[0] = 8'hff;
      gsel = s; // gpio function chosen before the pin is used as an edge input
      pd = (i % 4) != 3;
      acc(1'b1, 8'h03, w);
      repeat (3) @(negedge clk_sys);
      extV[0][i % 8] = 1'b0;
      n = 0;
      repeat (8) begin
        @(negedge clk_sys);
        n += (wake === 1'b1) ? 1 : 0;
      end
      chk(8'(pd & w[i % 8] & s[i % 8]), 8'(n));
    end
    $display("test wake done");
    end_of_test();
  end
endmodule
